// ### verilog/iolf_top.sv
// Line filter select, output write mask and interrupt mode logic for a
// 32-line general purpose I/O port, with its register slave.
// Assumes a one-cycle strobe register bus and asynchronous line pins.
`timescale 1ns/10ps
module iolf_top
    import iolf_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [31:0] i_pin,
    input wire logic [31:0] i_periph_a_out,
    input wire logic [31:0] i_periph_b_out,
    output logic [31:0] o_periph_a_in,
    output logic [31:0] o_periph_b_in,
    output logic [31:0] o_line_out,
    output logic [31:0] o_line_filtered,
    output logic o_irq
);
    logic [31:0] func_sel_reg;
    logic [31:0] debounce_sel_reg;
    logic [DIV_W-1:0] div_reg;
    logic [31:0] owr_en_reg;
    logic [31:0] out_data_reg;
    logic [31:0] xirq_reg;
    logic [31:0] level_mode_reg;
    logic [31:0] polarity_reg;
    logic wprot_reg;
    logic [31:0] irq_status_reg;
    logic [31:0] irq_enable_reg;
    logic [31:0] rdata_reg;
    logic [31:0] sync1_reg;
    logic [31:0] sync2_reg;
    logic [31:0] filt;
    logic [31:0] prev_reg;
    logic [31:0] event_hit;
    logic [15:0] slow_cnt_reg;
    logic slow_tick;
    logic [DIV_W-1:0] div_cnt_reg;
    logic half_tick;
    logic wr_ok;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            sync1_reg <= RESET_ZERO;
            sync2_reg <= RESET_ZERO;
        end else begin
            sync1_reg <= i_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // Slow clock enable from the master clock.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            slow_cnt_reg <= 16'h0000;
        end else if (slow_tick) begin
            slow_cnt_reg <= 16'h0000;
        end else begin
            slow_cnt_reg <= slow_cnt_reg + 16'h0001;
        end
    end
    assign slow_tick = (slow_cnt_reg == 16'(SLOW_TICK_CYCLES - 1));

    // divider: one half_tick each (div+1) slow periods
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            div_cnt_reg <= RESET_DIV;
        end else if (slow_tick) begin
            if (div_cnt_reg >= div_reg) begin
                div_cnt_reg <= RESET_DIV;
            end else begin
                div_cnt_reg <= div_cnt_reg + 14'h0001;
            end
        end
    end
    assign half_tick = slow_tick && (div_cnt_reg >= div_reg);

    genvar g;
    generate
        for (g = 0; g < NLINES; g++) begin : g_line
            iolf_line_filter u_filt (
                .i_sys_clk(i_sys_clk),
                .i_resetn(i_resetn),
                .i_pin(sync2_reg[g]),
                .i_debounce_sel(debounce_sel_reg[g]),
                .i_half_tick(half_tick),
                .o_level(filt[g])
            );
        end
    endgenerate
    assign o_line_filtered = filt;

    assign o_periph_a_in = filt & ~func_sel_reg;
    assign o_periph_b_in = filt & func_sel_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_line_out <= RESET_ZERO;
        end else begin
            o_line_out <= (i_periph_a_out & ~func_sel_reg)
                | (i_periph_b_out & func_sel_reg);
        end
    end

    assign wr_ok = i_wr && !wprot_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            wprot_reg <= 1'b0;
        end else if (i_wr && i_addr == ADDR_WPROT) begin
            wprot_reg <= i_wdata[WPROT_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            func_sel_reg <= RESET_ZERO;
        end else if (wr_ok && i_addr == ADDR_FUNC_SELECT) begin
            func_sel_reg <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            debounce_sel_reg <= RESET_ZERO;
        end else if (i_wr && i_addr == ADDR_GLITCH_SEL) begin
            debounce_sel_reg <= debounce_sel_reg & ~i_wdata;
        end else if (i_wr && i_addr == ADDR_DEBOUNCE_SEL) begin
            debounce_sel_reg <= debounce_sel_reg | i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            div_reg <= RESET_DIV;
        end else if (i_wr && i_addr == ADDR_DIVIDER) begin
            div_reg <= i_wdata[DIV_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            owr_en_reg <= RESET_OWR;
        end else if (wr_ok && i_addr == ADDR_OWR_ENABLE) begin
            owr_en_reg <= owr_en_reg | i_wdata;
        end else if (wr_ok && i_addr == ADDR_OWR_DISABLE) begin
            owr_en_reg <= owr_en_reg & ~i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            out_data_reg <= RESET_ZERO;
        end else if (i_wr && i_addr == ADDR_OUT_DATA) begin
            out_data_reg <= (out_data_reg & ~owr_en_reg)
                | (i_wdata & owr_en_reg);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            xirq_reg <= RESET_ZERO;
        end else if (i_wr && i_addr == ADDR_XIRQ_ENABLE) begin
            xirq_reg <= xirq_reg | i_wdata;
        end else if (i_wr && i_addr == ADDR_XIRQ_DISABLE) begin
            xirq_reg <= xirq_reg & ~i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            level_mode_reg <= RESET_ZERO;
        end else if (i_wr && i_addr == ADDR_EDGE_SEL) begin
            level_mode_reg <= level_mode_reg & ~i_wdata;
        end else if (i_wr && i_addr == ADDR_LEVEL_SEL) begin
            level_mode_reg <= level_mode_reg | i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            polarity_reg <= RESET_ZERO;
        end else if (i_wr && i_addr == ADDR_FALL_LOW_SEL) begin
            polarity_reg <= polarity_reg & ~i_wdata;
        end else if (i_wr && i_addr == ADDR_RISE_HIGH_SEL) begin
            polarity_reg <= polarity_reg | i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            prev_reg <= RESET_ZERO;
        end else begin
            prev_reg <= filt;
        end
    end

    always_comb begin
        for (int i = 0; i < NLINES; i++) begin
            if (!xirq_reg[i]) begin
                event_hit[i] = filt[i] ^ prev_reg[i];
            end else if (level_mode_reg[i]) begin
                event_hit[i] = (filt[i] == polarity_reg[i]);
            end else begin
                event_hit[i] = (filt[i] ^ prev_reg[i])
                    && (filt[i] == polarity_reg[i]);
            end
        end
    end

    // Set wins over a clear arriving in the same cycle.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            irq_status_reg <= RESET_ZERO;
        end else if (i_wr && i_addr == ADDR_IRQ_CLEAR) begin
            irq_status_reg <= (irq_status_reg & ~i_wdata) | event_hit;
        end else begin
            irq_status_reg <= irq_status_reg | event_hit;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            irq_enable_reg <= RESET_ZERO;
        end else if (i_wr && i_addr == ADDR_IRQ_ENABLE) begin
            irq_enable_reg <= i_wdata;
        end
    end
    assign o_irq = |(irq_status_reg & irq_enable_reg);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            rdata_reg <= RESET_ZERO;
        end else if (i_rd) begin
            unique case (i_addr)
                ADDR_FUNC_SELECT: rdata_reg <= func_sel_reg;
                ADDR_FILTER_STATUS: rdata_reg <= debounce_sel_reg;
                ADDR_DIVIDER: rdata_reg <= {18'h00000, div_reg};
                ADDR_OUT_DATA: rdata_reg <= out_data_reg;
                ADDR_OWR_STATUS: rdata_reg <= owr_en_reg;
                ADDR_XIRQ_STATUS: rdata_reg <= xirq_reg;
                ADDR_EDGE_LEVEL_ST: rdata_reg <= level_mode_reg;
                ADDR_POLARITY_ST: rdata_reg <= polarity_reg;
                ADDR_WPROT: rdata_reg <= {31'h00000000, wprot_reg};
                ADDR_IRQ_STATUS: rdata_reg <= irq_status_reg;
                ADDR_IRQ_ENABLE: rdata_reg <= irq_enable_reg;
                default: rdata_reg <= RESET_ZERO;
            endcase
        end else begin
            rdata_reg <= RESET_ZERO;
        end
    end
    assign o_rdata = rdata_reg;
endmodule // iolf_top

// ### verilog/iolf_pkg.sv
// Package for the I/O line filter, output mask and interrupt mode block.
// Assumes a 32-line port and a plain strobe register bus on one clock.
package iolf_pkg;
    localparam int NLINES = 32;
    localparam logic [31:0] ADDR_BASE = 32'h400e0c00;
    localparam logic [31:0] ADDR_FUNC_SELECT = 32'h400e0c70;
    localparam logic [31:0] ADDR_GLITCH_SEL = 32'h400e0c80;
    localparam logic [31:0] ADDR_DEBOUNCE_SEL = 32'h400e0c84;
    localparam logic [31:0] ADDR_FILTER_STATUS = 32'h400e0c88;
    localparam logic [31:0] ADDR_DIVIDER = 32'h400e0c8c;
    localparam logic [31:0] ADDR_OUT_DATA = 32'h400e0c38;
    localparam logic [31:0] ADDR_OWR_ENABLE = 32'h400e0ca0;
    localparam logic [31:0] ADDR_OWR_DISABLE = 32'h400e0ca4;
    localparam logic [31:0] ADDR_OWR_STATUS = 32'h400e0ca8;
    localparam logic [31:0] ADDR_XIRQ_ENABLE = 32'h400e0cb0;
    localparam logic [31:0] ADDR_XIRQ_DISABLE = 32'h400e0cb4;
    localparam logic [31:0] ADDR_XIRQ_STATUS = 32'h400e0cb8;
    localparam logic [31:0] ADDR_EDGE_SEL = 32'h400e0cc0;
    localparam logic [31:0] ADDR_LEVEL_SEL = 32'h400e0cc4;
    localparam logic [31:0] ADDR_EDGE_LEVEL_ST = 32'h400e0cc8;
    localparam logic [31:0] ADDR_FALL_LOW_SEL = 32'h400e0cd0;
    localparam logic [31:0] ADDR_RISE_HIGH_SEL = 32'h400e0cd4;
    localparam logic [31:0] ADDR_POLARITY_ST = 32'h400e0cd8;
    localparam logic [31:0] ADDR_WPROT = 32'h400e0ce4;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'h400e0d00;
    localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h400e0d04;
    localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h400e0d08;
    localparam int DIV_W = 14;
    localparam int WPROT_BIT = 0;
    localparam logic [31:0] RESET_ZERO = 32'h00000000;
    localparam logic [31:0] RESET_OWR = 32'h00000000;
    localparam logic [DIV_W-1:0] RESET_DIV = 14'h0000;
    // Slow clock tick: 32768 Hz nominal derived from the 20 MHz clock.
    localparam int CLK_HZ = 20000000;
    localparam int SLOW_HZ = 32768;
    localparam int SLOW_TICK_CYCLES = CLK_HZ / SLOW_HZ;
endpackage

// ### verilog/iolf_line_filter.sv
// One input line filter: glitch stage on every line, optional debounce.
// Assumes the pin is already synchronised and a slow tick pulse is given.
`timescale 1ns/10ps
module iolf_line_filter
    import iolf_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_pin,
    input wire logic i_debounce_sel,
    input wire logic i_half_tick,
    output logic o_level
);
    logic glitch_reg;
    logic cand_reg;
    logic stable_reg;
    logic [1:0] seen_reg;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            glitch_reg <= 1'b0;
        end else begin
            glitch_reg <= i_pin;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            cand_reg <= 1'b0;
            stable_reg <= 1'b0;
            seen_reg <= 2'h0;
        end else if (glitch_reg != cand_reg) begin
            cand_reg <= glitch_reg;
            seen_reg <= 2'h0;
        end else if (i_half_tick) begin
            // The level must survive two half-period ticks to pass.
            if (seen_reg == 2'h1) begin
                stable_reg <= cand_reg;
            end else begin
                seen_reg <= seen_reg + 2'h1;
            end
        end
    end

    assign o_level = i_debounce_sel ? stable_reg : glitch_reg;
endmodule // iolf_line_filter

// ### testbench/iolf_chk.sv
// Checker of the I/O line block, watching the top-level ports only.
// Assumes the shadow map below matches the register offsets in use.
`timescale 1ns/10ps
module iolf_chk
    import iolf_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [31:0] i_pin,
    input wire logic [31:0] i_periph_a_out,
    input wire logic [31:0] i_periph_b_out,
    input wire logic [31:0] o_periph_a_in,
    input wire logic [31:0] o_periph_b_in,
    input wire logic [31:0] o_line_out,
    input wire logic [31:0] o_line_filtered,
    input wire logic o_irq
);
    localparam logic [31:0] HOLE = 32'h400e0c90;
    logic [31:0] fk_reg, ow_reg, xm_reg, fs_reg, ie_reg;
    logic [DIV_W-1:0] dv_reg;
    logic wp_reg;
    logic [2:0] age_reg;
    wire [31:0] mux_w = (i_periph_a_out & ~fs_reg) |
        (i_periph_b_out & fs_reg);
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_resetn);
    // A shadow of the selection state lets the filter, output write, interrupt mode and divider reads be judged.
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            {fk_reg, ow_reg, xm_reg, fs_reg, ie_reg} <= '0;
            dv_reg <= '0;
            wp_reg <= 1'b0;
        end else if (i_wr) begin
            case (i_addr)
                ADDR_GLITCH_SEL: fk_reg <= fk_reg & ~i_wdata;
                ADDR_DEBOUNCE_SEL: fk_reg <= fk_reg | i_wdata;
                ADDR_OWR_ENABLE: if (!wp_reg) ow_reg <= ow_reg | i_wdata;
                ADDR_OWR_DISABLE: if (!wp_reg) ow_reg <= ow_reg & ~i_wdata;
                ADDR_FUNC_SELECT: if (!wp_reg) fs_reg <= i_wdata;
                ADDR_XIRQ_ENABLE: xm_reg <= xm_reg | i_wdata;
                ADDR_XIRQ_DISABLE: xm_reg <= xm_reg & ~i_wdata;
                ADDR_DIVIDER: dv_reg <= i_wdata[DIV_W-1:0];
                ADDR_IRQ_ENABLE: ie_reg <= i_wdata;
                ADDR_WPROT: wp_reg <= i_wdata[WPROT_BIT];
                default: ;
            endcase
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) age_reg <= 3'h0;
        else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
    end
    a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data not zero");
    a_owrite_read_back: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_OWR_STATUS
        |-> o_rdata == $past(ow_reg)) else $error("write status wrong");
    a_fkind_read_back: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_FILTER_STATUS
        |-> o_rdata == $past(fk_reg)) else $error("filter status wrong");
    a_div_read_back: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_DIVIDER
        |-> o_rdata == 32'($past(dv_reg))) else $error("divider wrong");
    a_xmode_read_back: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_XIRQ_STATUS
        |-> o_rdata == $past(xm_reg)) else $error("mode status wrong");
    a_hole_reads_zero: assert property (
        $past(i_rd) && $past(i_addr) == HOLE |-> o_rdata == '0)
        else $error("unmapped read not zero");
    a_line_out_mux: assert property (
        $past(i_resetn) |-> o_line_out == $past(mux_w))
        else $error("line routing wrong");
    a_periph_in_route: assert property (
        o_periph_a_in == (o_line_filtered & ~fs_reg)
        && o_periph_b_in == (o_line_filtered & fs_reg))
        else $error("input routing wrong");
    a_irq_masked: assert property (
        ie_reg == '0 && $past(ie_reg) == '0 |-> !o_irq)
        else $error("interrupt while masked");
    a_glitch_follow: assert property (
        age_reg == 3'h7 |-> ((o_line_filtered ^ $past(i_pin, 3)) & ~fk_reg
        & ~$past(fk_reg, 4) & ~($past(i_pin, 2) ^ $past(i_pin, 3))
        & ~($past(i_pin, 3) ^ $past(i_pin, 4))) == '0)
        else $error("filtered line wrong");
endmodule // iolf_chk

bind iolf_top iolf_chk chk_u (.i_sys_clk, .i_resetn, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_pin, .i_periph_a_out, .i_periph_b_out,
    .o_periph_a_in, .o_periph_b_in, .o_line_out, .o_line_filtered, .o_irq);

// ### testbench/iolf_tb_top.sv
// Self-checking bench of the I/O line block: random register traffic,
// routing and interrupt modes. Assumes the top runs alone on one clock.
`timescale 1ns/10ps
module iolf_tb_top
    import iolf_pkg::*;
;
    localparam logic [31:0] HOLE = 32'h400e0c90;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pend = 1'b0;
    logic wp, irq;
    logic [31:0] addr = '0, wd = '0, pin = '0, pa = '0, pb = '0;
    logic [31:0] rdat, lout, x, y, pexp, m_fk, m_ow, m_xm, m_fs, m_od, lf;
    logic [31:0] map [5] = '{ADDR_FILTER_STATUS, ADDR_OWR_STATUS,
        ADDR_XIRQ_STATUS, ADDR_DIVIDER, HOLE};
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    iolf_top dut_u (.i_sys_clk(clk), .i_resetn(rstn), .i_addr(addr),
        .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_pin(pin),
        .i_periph_a_out(pa), .i_periph_b_out(pb), .o_periph_a_in(),
        .o_periph_b_in(), .o_line_out(lout), .o_line_filtered(lf),
        .o_irq(irq));
    initial forever #25 clk = ~clk;
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Strobes stay up until the next call, so transfers run back to back.
    task automatic acc(input logic w, input logic r, input logic [31:0] a,
        input logic [31:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wd <= d;
        @(posedge clk);
        if (pend) chk(rdat, pexp);
        pend = r;
        pexp = d;
    endtask
    task automatic idle(input int n);
        repeat (n) acc(1'b0, 1'b0, '0, '0);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            results();
        end
    end
    initial begin
        void'($urandom(32'h8ddc));
        {m_fk, m_ow, m_xm, m_fs, m_od} = '0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        idle(1);
        foreach (map[i]) acc(0, 1, map[i], '0);
        $display("reset test done");
        for (int n = 0; n < 30; n++) begin
            x = $urandom();
            y = $urandom();
            wp = $urandom_range(3) == 0;
            acc(1, 0, ADDR_WPROT, {31'h0, wp});
            acc(1, 0, ADDR_GLITCH_SEL, x);
            acc(1, 0, ADDR_DEBOUNCE_SEL, y);
            acc(1, 0, ADDR_OWR_ENABLE, y);
            acc(1, 0, ADDR_OWR_DISABLE, x);
            acc(1, 0, ADDR_XIRQ_ENABLE, x);
            acc(1, 0, ADDR_XIRQ_DISABLE, y);
            acc(1, 0, ADDR_DIVIDER, x);
            acc(1, 0, ADDR_FUNC_SELECT, y);
            acc(1, 0, ADDR_OUT_DATA, x ^ y);
            m_fk = (m_fk & ~x) | y;
            m_xm = (m_xm | x) & ~y;
            if (!wp) m_ow = (m_ow | y) & ~x;
            if (!wp) m_fs = y;
            m_od = (m_od & ~m_ow) | ((x ^ y) & m_ow);
            pa <= $urandom();
            pb <= $urandom();
            acc(0, 1, ADDR_FILTER_STATUS, m_fk);
            acc(0, 1, ADDR_OWR_STATUS, m_ow);
            acc(0, 1, ADDR_XIRQ_STATUS, m_xm);
            acc(0, 1, ADDR_DIVIDER, {18'h0, x[13:0]});
            acc(0, 1, ADDR_OUT_DATA, m_od);
            acc(0, 1, ADDR_FUNC_SELECT, m_fs);
            acc(0, 1, HOLE, '0);
            chk(lout, (pa & ~m_fs) | (pb & m_fs));
        end
        $display("random test done");
        acc(1, 0, ADDR_WPROT, '0);
        acc(1, 0, ADDR_GLITCH_SEL, '1);
        acc(1, 0, ADDR_XIRQ_DISABLE, '1);
        acc(1, 0, ADDR_IRQ_ENABLE, 32'h1);
        acc(1, 0, ADDR_IRQ_CLEAR, '1);
        pin <= 32'h1;
        idle(6);
        chk({31'h0, irq}, 32'h1);
        acc(1, 0, ADDR_IRQ_ENABLE, '0);
        idle(2);
        chk({31'h0, irq}, 32'h0);
        acc(1, 0, ADDR_XIRQ_ENABLE, 32'h1);
        acc(1, 0, ADDR_EDGE_SEL, 32'h1);
        acc(1, 0, ADDR_FALL_LOW_SEL, 32'h1);
        acc(1, 0, ADDR_IRQ_CLEAR, 32'h1);
        pin <= 32'h0;
        idle(6);
        acc(0, 1, ADDR_IRQ_STATUS, 32'h1);
        acc(1, 0, ADDR_IRQ_CLEAR, 32'h1);
        pin <= 32'h1;
        idle(6);
        acc(0, 1, ADDR_IRQ_STATUS, 32'h0);
        acc(1, 0, ADDR_LEVEL_SEL, 32'h1);
        acc(1, 0, ADDR_RISE_HIGH_SEL, 32'h1);
        acc(1, 0, ADDR_IRQ_CLEAR, 32'h1);
        idle(3);
        acc(0, 1, ADDR_IRQ_STATUS, 32'h1);
        acc(0, 1, ADDR_EDGE_LEVEL_ST, 32'h1);
        acc(0, 1, ADDR_POLARITY_ST, 32'h1);
        idle(1);
        $display("interrupt test done");
        acc(1, 0, ADDR_DIVIDER, '0);
        acc(1, 0, ADDR_DEBOUNCE_SEL, 32'h2);
        // With the divider at zero a level must outlast two slow ticks.
        pin <= 32'h3;
        idle(300);
        pin <= 32'h1;
        idle(700);
        chk(lf & 32'h2, 32'h0);
        pin <= 32'h3;
        idle(600);
        chk(lf & 32'h2, 32'h0);
        idle(700);
        chk(lf & 32'h2, 32'h2);
        $display("debounce test done");
        results();
    end
endmodule // iolf_tb_top
